//--- hw/rgb_led_pwm_pdm_modulator.sv
/*
 * rgb_led_pwm_pdm_modulator: three LED drive lines from a shared-timer
 * pulse-width modulator or a per-colour pulse-density modulator.
 * Assumes an Avalon-MM master that holds its request until waitrequest
 * is low; one clock, asynchronous active-high reset.
 */
// Notes on behaviour
// - three separate drive lines, brightness purely from high/low pattern
// - one programmable period limit sets the period of all channels
// - each channel holds a writable buffered duty value
// - period start clears timer and copies buffer into active duty
// - timer equal to active duty drives that line low for the period
// - timer reaching limit reloads duty from buffer and drives lines with nonzero duty high
// - each period rollover sets a sticky period-end flag
// - red, green, blue use first, third, second compare channels
// - pulse-density value added to accumulator once per modulator tick
// - pulse-density output equals accumulator carry-out
// - each pulse-density high lasts one tick; back-to-back highs allowed
// - a dedicated periodic tick paces the pulse-density steps
// - three 16-bit accumulators, one per colour
// - each tick adds the 8-bit colour value into its accumulator
// - carry bit above the low eight bits drives the colour line
// - accumulator masked to low eight bits after the carry is taken
`default_nettype none
module rgb_led_pwm_pdm_modulator (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [5:0]       avs_address,
	input  wire logic [31:0]      avs_writedata,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	output logic                  red_drive,
	output logic                  green_drive,
	output logic                  blue_drive,
	output logic                  irq
);
	rgb_pkg::rgb_state_t st_reg;
	rgb_pkg::rgb_state_t st_next;
	rgb_pkg::rgb_req_t   req;

	// one driver for the whole carrier, fields in declaration order
	assign req = {avs_read, avs_write, avs_address, avs_writedata};

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	logic            access;
	logic            wrStb;
	logic            periodEnd;
	logic            pdmTick;
	logic [15:0]     sum;
	logic [rgb_pkg::ST_W-1:0] events;
	logic [31:0]     rd;

	always_comb begin
		st_next   = st_reg;
		sum       = 16'h0000;
		rd        = 32'h0000_0000;
		// one wait cycle: answer on the edge after the request is seen
		access    = (req.read | req.write) & ~st_reg.ack;
		wrStb     = req.write & ~st_reg.ack;
		st_next.ack = access;
		periodEnd = 1'b0;
		pdmTick   = 1'b0;

		if (st_reg.enable && !st_reg.pdmMode) begin
			if (st_reg.timer >= st_reg.periodLimit) begin
				periodEnd     = 1'b1;
				st_next.timer = 16'h0000;
				for (int i = 0; i < rgb_pkg::N_CH; i++) begin
					st_next.dutyActive[i] = st_reg.dutyBuffer[i];
					// zero duty stays dark for the whole period
					st_next.drive[i] = (st_reg.dutyBuffer[i] != 16'h0000);
				end
			end else begin
				st_next.timer = st_reg.timer + 16'h0001;
				for (int i = 0; i < rgb_pkg::N_CH; i++) begin
					if (st_next.timer == st_reg.dutyActive[i])
						st_next.drive[i] = 1'b0;
				end
			end
		end

		if (st_reg.enable && st_reg.pdmMode) begin
			if (st_reg.tickCnt >= st_reg.tickDiv) begin
				pdmTick         = 1'b1;
				st_next.tickCnt = 16'h0000;
				for (int i = 0; i < rgb_pkg::N_CH; i++) begin
					sum = st_reg.accum[i] + {8'h00, st_reg.colorValue[i]};
					st_next.drive[i] = sum[rgb_pkg::CARRY_BIT];
					st_next.accum[i] = {8'h00, sum[7:0]};
				end
			end else begin
				st_next.tickCnt = st_reg.tickCnt + 16'h0001;
			end
		end

		if (!st_reg.enable) begin
			st_next.drive   = 3'h0;
			st_next.timer   = 16'h0000;
			st_next.tickCnt = 16'h0000;
		end

		events = {pdmTick, periodEnd};

		// register read mux
		case (req.address)
			rgb_pkg::OFF_CTRL:    rd = {30'h0, st_reg.pdmMode, st_reg.enable};
			rgb_pkg::OFF_PERIOD:  rd = {16'h0, st_reg.periodLimit};
			rgb_pkg::OFF_DUTY_R:  rd = {16'h0, st_reg.dutyBuffer[rgb_pkg::CH_R]};
			rgb_pkg::OFF_DUTY_G:  rd = {16'h0, st_reg.dutyBuffer[rgb_pkg::CH_G]};
			rgb_pkg::OFF_DUTY_B:  rd = {16'h0, st_reg.dutyBuffer[rgb_pkg::CH_B]};
			rgb_pkg::OFF_STATUS:  rd = {30'h0, st_reg.status};
			rgb_pkg::OFF_MASK:    rd = {30'h0, st_reg.mask};
			rgb_pkg::OFF_COLOR:   rd = {8'h00, st_reg.colorValue[rgb_pkg::CH_B],
				st_reg.colorValue[rgb_pkg::CH_G], st_reg.colorValue[rgb_pkg::CH_R]};
			rgb_pkg::OFF_TICKDIV: rd = {16'h0, st_reg.tickDiv};
			rgb_pkg::OFF_TIMER:   rd = {16'h0, st_reg.timer};
			default:              rd = 32'h0000_0000;
		endcase
		if (req.read && access)
			st_next.rdata = rd;

		// register writes
		if (wrStb) begin
			case (req.address)
				rgb_pkg::OFF_CTRL: begin
					st_next.enable  = req.writedata[rgb_pkg::CTRL_EN];
					st_next.pdmMode = req.writedata[rgb_pkg::CTRL_PDM];
				end
				rgb_pkg::OFF_PERIOD:
					st_next.periodLimit = req.writedata[15:0];
				// new colour goes to buffers only; active duty follows at period end
				rgb_pkg::OFF_DUTY_R:
					st_next.dutyBuffer[rgb_pkg::CH_R] = req.writedata[15:0];
				rgb_pkg::OFF_DUTY_G:
					st_next.dutyBuffer[rgb_pkg::CH_G] = req.writedata[15:0];
				rgb_pkg::OFF_DUTY_B:
					st_next.dutyBuffer[rgb_pkg::CH_B] = req.writedata[15:0];
				rgb_pkg::OFF_STATUS:
					st_next.status = st_reg.status & ~req.writedata[rgb_pkg::ST_W-1:0];
				rgb_pkg::OFF_MASK:
					st_next.mask = req.writedata[rgb_pkg::ST_W-1:0];
				rgb_pkg::OFF_COLOR: begin
					st_next.colorValue[rgb_pkg::CH_R] = req.writedata[rgb_pkg::COL_R_LSB +: 8];
					st_next.colorValue[rgb_pkg::CH_G] = req.writedata[rgb_pkg::COL_G_LSB +: 8];
					st_next.colorValue[rgb_pkg::CH_B] = req.writedata[rgb_pkg::COL_B_LSB +: 8];
				end
				rgb_pkg::OFF_TICKDIV:
					st_next.tickDiv = req.writedata[15:0];
				default: begin
				end
			endcase
		end

		// set beats a simultaneous clear
		st_next.status = st_next.status | events;
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg             <= '0;
			st_reg.periodLimit <= rgb_pkg::PERIOD_RST;
			st_reg.tickDiv     <= rgb_pkg::TICKDIV_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign avs_waitrequest = (avs_read | avs_write) & ~st_reg.ack;
	assign avs_readdata    = st_reg.rdata;
	assign red_drive       = st_reg.drive[rgb_pkg::CH_R];
	assign green_drive     = st_reg.drive[rgb_pkg::CH_G];
	assign blue_drive      = st_reg.drive[rgb_pkg::CH_B];
	assign irq             = |(st_reg.status & st_reg.mask);
endmodule : rgb_led_pwm_pdm_modulator
`default_nettype wire

//--- hw/rgb_pkg.sv
/*
 * rgb_pkg: register map, field layout, reset values and timing for the
 * tri-colour LED modulator.
 * Assumes a single 40 MHz clock and a 32-bit Avalon-MM register bus.
 */
`default_nettype none
package rgb_pkg;
	localparam int unsigned CLK_HZ      = 40_000_000;
	localparam int unsigned ADDR_W      = 6;
	// byte offsets
	localparam logic [5:0] OFF_CTRL     = 6'h00;
	localparam logic [5:0] OFF_PERIOD   = 6'h04;
	localparam logic [5:0] OFF_DUTY_R   = 6'h08;
	localparam logic [5:0] OFF_DUTY_G   = 6'h0c;
	localparam logic [5:0] OFF_DUTY_B   = 6'h10;
	localparam logic [5:0] OFF_STATUS   = 6'h14;
	localparam logic [5:0] OFF_MASK     = 6'h18;
	localparam logic [5:0] OFF_COLOR    = 6'h1c;
	localparam logic [5:0] OFF_TICKDIV  = 6'h20;
	localparam logic [5:0] OFF_TIMER    = 6'h24;
	// ctrl fields
	localparam int unsigned CTRL_EN     = 0;
	localparam int unsigned CTRL_PDM    = 1;
	// status fields
	localparam int unsigned ST_PEND     = 0;
	localparam int unsigned ST_TICK     = 1;
	localparam int unsigned ST_W        = 2;
	// colour field positions in OFF_COLOR
	localparam int unsigned COL_R_LSB   = 0;
	localparam int unsigned COL_G_LSB   = 8;
	localparam int unsigned COL_B_LSB   = 16;
	// reset values, carry bit position and channel count
	localparam logic [15:0] PERIOD_RST  = 16'hffff;
	localparam logic [15:0] TICKDIV_RST = 16'h00c7;
	localparam int unsigned CARRY_BIT   = 8;
	localparam int unsigned N_CH        = 3;
	// channel index: red first, green third, blue second compare channel
	localparam int unsigned CH_R        = 0;
	localparam int unsigned CH_G        = 2;
	localparam int unsigned CH_B        = 1;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [5:0]  address;
		logic [31:0] writedata;
	} rgb_req_t;

	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
	} rgb_rsp_t;

	typedef struct packed {
		logic                   enable;
		logic                   pdmMode;
		logic [15:0]            periodLimit;
		logic [15:0]            timer;
		logic [2:0][15:0]       dutyBuffer;
		logic [2:0][15:0]       dutyActive;
		logic [2:0][7:0]        colorValue;
		logic [2:0][15:0]       accum;
		logic [15:0]            tickDiv;
		logic [15:0]            tickCnt;
		logic [2:0]             drive;
		logic [ST_W-1:0]        status;
		logic [ST_W-1:0]        mask;
		logic                   ack;
		logic [31:0]            rdata;
	} rgb_state_t;
endpackage : rgb_pkg
`default_nettype wire

//--- verification/rgb_props.sv
/* rgb_props: bus and drive-line checks of the LED modulator.
   Bound into the top module; sees its ports only. */
`default_nettype none
module rgb_props (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [5:0]  avs_address,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        red_drive,
	input wire logic        green_drive,
	input wire logic        blue_drive,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic  req  = avs_read | avs_write;
	wire logic  take = req & ~avs_waitrequest;
	wire logic  wrSeen = avs_write & avs_waitrequest;
	wire logic  dark = ~(red_drive | green_drive | blue_drive);
	logic       enSh;
	logic [1:0] maskSh;
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	// shadows follow the edge where the block commits a write: the first,
	// still-waiting cycle of the request, not the answer edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			enSh   <= 1'h0;
			maskSh <= 2'h0;
		end else if (wrSeen && avs_address == rgb_pkg::OFF_CTRL) begin
			enSh <= avs_writedata[0];
		end else if (wrSeen && avs_address == rgb_pkg::OFF_MASK) begin
			maskSh <= avs_writedata[1:0];
		end
	end
	sequence sOneWait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	chk_one_wait: assert property ($rose(req) |-> sOneWait)
		else $error("request not answered after one wait cycle");
	chk_idle_ready: assert property (!req |-> !avs_waitrequest)
		else $error("waitrequest without a request");
	chk_ack_toggle: assert property (take |=> !take)
		else $error("two answers in a row");
	chk_rd_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	chk_reset_dark: assert property ($fell(sys_rst) |-> dark && !irq)
		else $error("lines lit right after reset");
	chk_off_dark: assert property (!enSh [*2] |-> dark)
		else $error("line lit while disabled");
	chk_irq_masked: assert property (maskSh == 2'h0 [*2] |-> !irq)
		else $error("interrupt with all events masked");
	chk_irq_cause: assert property ($rose(irq) |-> maskSh != 2'h0)
		else $error("interrupt rose with no unmasked event");
endmodule : rgb_props
bind rgb_led_pwm_pdm_modulator rgb_props props (.clk(clk), .sys_rst(sys_rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_address(avs_address),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .red_drive(red_drive),
	.green_drive(green_drive), .blue_drive(blue_drive), .irq(irq));
`default_nettype wire

//--- verification/rgb_led_model.sv
/* rgb_led_model: the tri-colour LED, counting lit clocks per colour.
   Assumes high drive means lit, sampled on the rising clock. */
`default_nettype none
module rgb_led_model (
	input  wire logic             clk,
	input  wire logic             clear,
	input  wire logic             redDrive,
	input  wire logic             greenDrive,
	input  wire logic             blueDrive,
	output logic      [2:0][15:0] lit
);
	timeunit 1ns;
	timeprecision 1ps;
	// seen brightness is the share of lit clocks; unknowns poison the count
	always_ff @(posedge clk) begin
		if (clear) begin
			lit <= '0;
		end else begin
			lit[0] <= lit[0] + 16'(redDrive);
			lit[1] <= lit[1] + 16'(greenDrive);
			lit[2] <= lit[2] + 16'(blueDrive);
		end
	end
endmodule : rgb_led_model
`default_nettype wire

//--- verification/rgb_led_pwm_pdm_modulator_tb.sv
/* rgb_led_pwm_pdm_modulator_tb: register tests of both modulators.
   Needs the package, the LED model and the bound checker. */
`default_nettype none
module rgb_led_pwm_pdm_modulator_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk = 1'h0;
	logic             sysRst = 1'h1;
	logic             avsRead = 1'h0;
	logic             avsWrite = 1'h0;
	logic             ledClear = 1'h1;
	logic [5:0]       avsAddress = 6'h00;
	logic [31:0]      avsWritedata = 32'h0;
	logic [31:0]      avsReaddata, q;
	logic             avsWaitrequest, redDrive, greenDrive, blueDrive, irq;
	logic [2:0][15:0] lit, e;
	logic [31:0]      pwm [2][4] = '{'{32'h9, 32'h3, 32'h0, 32'hc}, '{32'h4, 32'h4, 32'h1, 32'h2}};
	int               miscompares = 0;
	int               nTests = 0;
	int               cycles = 0;
	always #12.5 clk = ~clk;
	rgb_led_pwm_pdm_modulator DUT (.clk(clk), .sys_rst(sysRst), .avs_read(avsRead),
		.avs_write(avsWrite), .avs_address(avsAddress), .avs_writedata(avsWritedata),
		.avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .red_drive(redDrive),
		.green_drive(greenDrive), .blue_drive(blueDrive), .irq(irq));
	rgb_led_model led (.clk(clk), .clear(ledClear), .redDrive(redDrive),
		.greenDrive(greenDrive), .blueDrive(blueDrive), .lit(lit));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
		nTests++;
		if (y !== x) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, x, y);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		avsRead      <= ~w;
		avsWrite     <= w;
		avsAddress   <= a;
		avsWritedata <= d;
		// the answer edge is the rising edge that sees waitrequest low
		do @(posedge clk); while (avsWaitrequest !== 1'h0);
		q = avsReaddata;
		avsRead  <= 1'h0;
		avsWrite <= 1'h0;
	endtask : bus
	// any window of whole periods holds exactly the lit share
	task automatic glow(input int len);
		repeat (40) @(posedge clk);
		ledClear <= 1'h0;
		repeat (len) @(posedge clk);
		ledClear <= 1'h1;
		@(negedge clk);
		for (int c = 0; c < 3; c++) chk("lit", 32'(e[c]), 32'(lit[c]));
	endtask : glow
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		sysRst <= 1'h0;
		chk("dark", 32'h0, {28'h0, irq, redDrive, greenDrive, blueDrive});
		bus(1'h0, rgb_pkg::OFF_PERIOD, 32'h0);
		chk("period", {16'h0, rgb_pkg::PERIOD_RST}, q);
		bus(1'h0, 6'h3c, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("reset test done");
		foreach (pwm[i]) begin
			bus(1'h1, rgb_pkg::OFF_PERIOD, pwm[i][0]);
			for (int c = 0; c < 3; c++) begin
				bus(1'h1, rgb_pkg::OFF_DUTY_R + 6'(4 * c), pwm[i][c + 1]);
				e[c] = 16'((pwm[i][c + 1] > pwm[i][0] ? pwm[i][0] + 1 : pwm[i][c + 1]) * 100
					/ (pwm[i][0] + 1));
			end
			bus(1'h1, rgb_pkg::OFF_CTRL, 32'h1);
			glow(100);
		end
		$display("pwm test done");
		bus(1'h0, rgb_pkg::OFF_STATUS, 32'h0);
		chk("pend", 32'h1, q & 32'h1);
		chk("irqoff", 32'h0, {31'h0, irq});
		bus(1'h1, rgb_pkg::OFF_MASK, 32'h1);
		repeat (2) @(negedge clk);
		chk("irqon", 32'h1, {31'h0, irq});
		bus(1'h1, rgb_pkg::OFF_CTRL, 32'h0);
		bus(1'h1, rgb_pkg::OFF_STATUS, 32'h3);
		repeat (2) @(negedge clk);
		chk("irqclr", 32'h0, {31'h0, irq});
		$display("event test done");
		bus(1'h1, rgb_pkg::OFF_TICKDIV, 32'h0);
		bus(1'h1, rgb_pkg::OFF_COLOR, 32'h0080_01ff);
		bus(1'h0, rgb_pkg::OFF_COLOR, 32'h0);
		chk("color", 32'h0080_01ff, q);
		bus(1'h1, rgb_pkg::OFF_CTRL, 32'h3);
		e = {16'h0080, 16'h0001, 16'h00ff};
		glow(256);
		bus(1'h0, rgb_pkg::OFF_STATUS, 32'h0);
		chk("tick", 32'h2, q & 32'h3);
		$display("pdm test done");
		print_verdict();
	end
endmodule : rgb_led_pwm_pdm_modulator_tb
`default_nettype wire
